// file: design/ofd_decoder.sv
/*
 * Operand field decoder: gathers opcode and operand bytes from the fetch
 * stream and presents resolved operand fields to the datapath.
 * Assumes fetch offers one byte per cycle with its address, same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module ofd_decoder (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // fetch stream
    input wire logic FETCH_VALID_I,
    input wire ofd_pkg::ofd_fetch_t FETCH_I,
    // register pointer from the flags/control file
    input wire logic [7:0] WORKING_GROUP_POINTER_I,
    // decoded instruction
    output logic [$bits(ofd_pkg::ofd_decode_t)-1:0] DECODE_O
);
    import ofd_pkg::*;

    ofd_regs_t r;
    ofd_regs_t next_r;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // escaped byte takes the low nibble inside the current working group
    function automatic logic [11:0] reg_addr(input logic [7:0] b,
                                             input logic [7:0] wgp);
        if (b[7:4] == ESC_NIBBLE) begin
            reg_addr = {4'h0, wgp[7:4], b[3:0]};
        end else begin
            reg_addr = {4'h0, b};
        end
    endfunction

    // pairs are forced even; hardware ignores an odd low bit
    function automatic logic [11:0] pair_addr(input logic [7:0] b,
                                              input logic [7:0] wgp);
        logic [11:0] a;
        a = reg_addr(b, wgp);
        pair_addr = {a[11:1], 1'b0};
    endfunction

    function automatic logic [1:0] len_of(input ofd_kind_t k);
        unique case (k)
            K_ADD_RR, K_ADD_IM, K_BIT, K_DA, K_IDX: len_of = 2'd2;
            K_EXT: len_of = 2'd3;
            default: len_of = 2'd1;
        endcase
    endfunction

    function automatic ofd_kind_t kind_of(input logic [7:0] op);
        unique case (op)
            OP_ADD_RR, OP_ADD_IR: kind_of = K_ADD_RR;
            OP_ADD_IM: kind_of = K_ADD_IM;
            OP_JR: kind_of = K_JR;
            OP_JP_DA, OP_CALL_DA: kind_of = K_DA;
            OP_TRAP: kind_of = K_TRAP;
            OP_BIT: kind_of = K_BIT;
            OP_INCW: kind_of = K_PAIR;
            OP_INCW_WP: kind_of = K_WPAIR;
            OP_LDX: kind_of = K_EXT;
            OP_LDX_IDX: kind_of = K_IDX;
            default: kind_of = K_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] b;
        logic [15:0] nxt;
        logic [7:0] wgp;
        b = FETCH_I.byte_val;
        wgp = WORKING_GROUP_POINTER_I;
        nxt = FETCH_I.addr + 16'h0001;
        next_r = r;
        next_r.out.valid = 1'b0;
        if (FETCH_VALID_I) begin
            unique case (r.st)
                S_OPC: begin
                    next_r.kind = kind_of(b);
                    next_r.out = '0;
                    next_r.out.opcode = b;
                    if (kind_of(b) == K_NONE) begin
                        next_r.out.valid = 1'b1;
                        next_r.out.illegal = 1'b1;
                    end else begin
                        next_r.st = S_B1;
                    end
                end
                S_B1: begin
                    next_r.b1 = b;
                    if (len_of(r.kind) == 2'd1) begin
                        next_r.st = S_OPC;
                        next_r.out.valid = 1'b1;
                        unique case (r.kind)
                            K_JR: begin
                                // offset counts from the next instruction
                                next_r.out.branch_target =
                                    nxt + {{8{b[7]}}, b};
                            end
                            K_TRAP: next_r.out.trap_vector = b;
                            K_PAIR: begin
                                next_r.out.dst_reg =
                                    pair_addr(b, wgp);
                            end
                            default: begin
                                // working pair: low nibble, even only
                                next_r.out.dst_reg = {4'h0,
                                    WORKING_GROUP_POINTER_I[7:4],
                                    b[3:1], 1'b0};
                            end
                        endcase
                    end else begin
                        next_r.st = S_B2;
                    end
                end
                S_B2: begin
                    next_r.b2 = b;
                    if (len_of(r.kind) == 2'd2) begin
                        next_r.st = S_OPC;
                        next_r.out.valid = 1'b1;
                        unique case (r.kind)
                            K_ADD_RR: begin
                                // object order is source, then destination
                                next_r.out.src_reg =
                                    reg_addr(r.b1, wgp);
                                next_r.out.dst_reg =
                                    reg_addr(b, wgp);
                            end
                            K_ADD_IM: begin
                                // immediate form puts destination first
                                next_r.out.dst_reg =
                                    reg_addr(r.b1, wgp);
                                next_r.out.literal_byte_operand = b;
                            end
                            K_BIT: begin
                                next_r.out.polarity = r.b1[BIT_POL_POS];
                                next_r.out.bit_num =
                                    r.b1[BIT_NUM_LSB +: 3];
                                next_r.out.dst_reg = {4'h0,
                                    WORKING_GROUP_POINTER_I[7:4],
                                    r.b1[BIT_REG_LSB +: 4]};
                            end
                            K_IDX: begin
                                next_r.out.src_reg =
                                    reg_addr(r.b1, WORKING_GROUP_POINTER_I);
                                next_r.out.index_disp = b;
                            end
                            default: begin
                                next_r.out.absolute_target_operand =
                                    {r.b1, b};
                            end
                        endcase
                    end else begin
                        next_r.st = S_B3;
                    end
                end
                S_B3: begin
                    // extended form: src 12 bits, then dst 12 bits
                    next_r.st = S_OPC;
                    next_r.out.valid = 1'b1;
                    next_r.out.src_reg = {r.b1, r.b2[7:4]};
                    next_r.out.dst_reg = {r.b2[3:0], b};
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign DECODE_O = r.out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    add_order_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_ADD_RR
         && r.out.opcode == OP_ADD_RR && r.b1[7:4] != ESC_NIBBLE)
        |=> (r.out.valid && r.out.src_reg == {4'h0, $past(r.b1)}))
        else $error("add source field wrong");
    add_dst_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_ADD_RR
         && FETCH_I.byte_val[7:4] != ESC_NIBBLE)
        |=> r.out.dst_reg[7:0] == $past(FETCH_I.byte_val))
        else $error("add destination field wrong");
    esc_reg_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_ADD_RR
         && r.b1[7:4] == ESC_NIBBLE)
        |=> r.out.src_reg[3:0] == $past(r.b1[3:0])
            && r.out.src_reg[7:4] == $past(WORKING_GROUP_POINTER_I[7:4]))
        else $error("escaped register not combined");
    esc_range_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        r.out.valid && r.kind == K_ADD_RR |-> r.out.src_reg[11:8] == 4'h0)
        else $error("register address out of range");
    pair_even_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        r.out.valid && (r.kind == K_PAIR || r.kind == K_WPAIR)
        |-> !r.out.dst_reg[0])
        else $error("pair address odd");
    rel_tgt_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B1 && r.kind == K_JR)
        |=> r.out.branch_target == 16'($past(FETCH_I.addr) + 16'h0001
            + {{8{$past(FETCH_I.byte_val[7])}}, $past(FETCH_I.byte_val)}))
        else $error("relative target wrong");
    bit_field_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_BIT)
        |=> r.out.bit_num == $past(r.b1[6:4])
            && r.out.polarity == $past(r.b1[7]))
        else $error("bit fields wrong");
    trap_vec_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B1 && r.kind == K_TRAP)
        |=> r.out.valid && r.out.trap_vector == $past(FETCH_I.byte_val))
        else $error("trap vector wrong");
    ext_addr_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B3)
        |=> r.out.dst_reg == {$past(r.b2[3:0]), $past(FETCH_I.byte_val)})
        else $error("extended address wrong");
    da_addr_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_DA)
        |=> r.out.absolute_target_operand
            == {$past(r.b1), $past(FETCH_I.byte_val)})
        else $error("direct address wrong");

    // ------------------------------------------------------------
    // opcode capture, idle hold, operand count and operand field checks
    // ------------------------------------------------------------
    opc_take_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_OPC)
        |=> r.out.valid == r.out.illegal
            && r.out.opcode == $past(FETCH_I.byte_val))
        else $error("opcode capture wrong");
    idle_hold_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        !FETCH_VALID_I
        |=> !r.out.valid && r.st == $past(r.st)
            && r.out.dst_reg == $past(r.out.dst_reg))
        else $error("state moved on an idle cycle");
    add_len_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B1 && r.kind == K_ADD_RR)
        |=> !r.out.valid && r.st == S_B2 && r.b1 == $past(FETCH_I.byte_val))
        else $error("add operand count wrong");
    esc_dst_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_ADD_RR
         && FETCH_I.byte_val[7:4] == ESC_NIBBLE)
        |=> r.out.dst_reg == {4'h0, $past(WORKING_GROUP_POINTER_I[7:4]),
            $past(FETCH_I.byte_val[3:0])})
        else $error("escaped destination not combined");
    imm_dst_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_ADD_IM
         && r.b1[7:4] != ESC_NIBBLE)
        |=> r.out.dst_reg == {4'h0, $past(r.b1)})
        else $error("immediate destination wrong");
    imm_data_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_ADD_IM)
        |=> r.out.literal_byte_operand == $past(FETCH_I.byte_val))
        else $error("literal byte wrong");
    bit_reg_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_BIT)
        |=> r.out.dst_reg == {4'h0, $past(WORKING_GROUP_POINTER_I[7:4]),
            $past(r.b1[3:0])})
        else $error("bit register wrong");
    pair_val_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B1 && r.kind == K_PAIR
         && FETCH_I.byte_val[7:4] != ESC_NIBBLE)
        |=> r.out.dst_reg == {4'h0, $past(FETCH_I.byte_val[7:1]), 1'b0})
        else $error("pair address wrong");
    wpair_val_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B1 && r.kind == K_WPAIR)
        |=> r.out.dst_reg == {4'h0, $past(WORKING_GROUP_POINTER_I[7:4]),
            $past(FETCH_I.byte_val[3:1]), 1'b0})
        else $error("working pair wrong");
    idx_disp_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_IDX
         && r.b1[7:4] != ESC_NIBBLE)
        |=> r.out.index_disp == $past(FETCH_I.byte_val)
            && r.out.src_reg == {4'h0, $past(r.b1)})
        else $error("indexed operand wrong");
    ext_len_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B2 && r.kind == K_EXT)
        |=> !r.out.valid && r.st == S_B3)
        else $error("extended operand count wrong");
    ext_src_a: assert property (@(posedge CORE_CLK_I)
        disable iff (RESET_I)
        (FETCH_VALID_I && r.st == S_B3)
        |=> r.out.src_reg == {$past(r.b1), $past(r.b2[7:4])})
        else $error("extended source wrong");

endmodule
`default_nettype wire

// file: design/ofd_pkg.sv
/*
 * Constants and types for the operand decoder.
 * Assumes a single 125 MHz synchronous clock domain shared with the fetch unit.
 */
package ofd_pkg;

    // ------------------------------------------------------------
    // opcodes and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ADD_RR = 8'h04;
    localparam logic [7:0] OP_ADD_IR = 8'h05;
    localparam logic [7:0] OP_ADD_IM = 8'h06;
    localparam logic [7:0] OP_JR = 8'h8b;
    localparam logic [7:0] OP_JP_DA = 8'h8d;
    localparam logic [7:0] OP_CALL_DA = 8'hd6;
    localparam logic [7:0] OP_TRAP = 8'hf2;
    localparam logic [7:0] OP_BIT = 8'he2;
    localparam logic [7:0] OP_INCW = 8'ha0;
    localparam logic [7:0] OP_INCW_WP = 8'ha1;
    localparam logic [7:0] OP_LDX = 8'he8;
    localparam logic [7:0] OP_LDX_IDX = 8'hc7;
    localparam logic [3:0] ESC_NIBBLE = 4'he;
    localparam int BIT_POL_POS = 7;
    localparam int BIT_NUM_LSB = 4;
    localparam int BIT_REG_LSB = 0;

    // ------------------------------------------------------------
    // decode kinds and states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        K_NONE = 4'h0, K_ADD_RR = 4'h1, K_ADD_IM = 4'h2, K_JR = 4'h3,
        K_DA = 4'h4, K_TRAP = 4'h5, K_BIT = 4'h6, K_PAIR = 4'h7,
        K_WPAIR = 4'h8, K_EXT = 4'h9, K_IDX = 4'ha
    } ofd_kind_t;

    typedef enum logic [1:0] {
        S_OPC = 2'b00, S_B1 = 2'b01, S_B2 = 2'b10, S_B3 = 2'b11
    } ofd_state_t;

    typedef struct packed {
        logic [7:0] byte_val;
        logic [15:0] addr;
    } ofd_fetch_t;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic [7:0] opcode;
        logic [11:0] src_reg;
        logic [11:0] dst_reg;
        logic [7:0] literal_byte_operand;
        logic [2:0] bit_num;
        logic polarity;
        logic [15:0] absolute_target_operand;
        logic [15:0] branch_target;
        logic [7:0] trap_vector;
        logic [7:0] index_disp;
    } ofd_decode_t;

    typedef struct packed {
        ofd_state_t st;
        ofd_kind_t kind;
        logic [7:0] b1;
        logic [7:0] b2;
        ofd_decode_t out;
    } ofd_regs_t;

endpackage

// file: testbench/cpu_operand_field_decoder_test.sv
/*
 * Self-checking bench for the operand field decoder.
 * Assumes the fetch model drives bytes at falling edges, one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    err_count++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end end
module cpu_operand_field_decoder_test;
    import ofd_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic fetch_valid;
    ofd_fetch_t fetch;
    logic [7:0] wgp = 8'h30;
    logic [$bits(ofd_decode_t)-1:0] decode_raw;
    ofd_decode_t d;
    int err_count = 0;
    int n_checks = 0;
    always #4 core_clk = ~core_clk;
    assign d = ofd_decode_t'(decode_raw);
    ofd_fetch_model fm (.clk_i(core_clk), .valid_o(fetch_valid),
        .fetch_o(fetch));
    ofd_decoder DUT (.CORE_CLK_I(core_clk), .RESET_I(reset),
        .FETCH_VALID_I(fetch_valid), .FETCH_I(fetch),
        .WORKING_GROUP_POINTER_I(wgp), .DECODE_O(decode_raw));
    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    // sampled at the falling edge after the last byte is taken
    task automatic instr(input logic [7:0] b0, b1, b2, b3, input int n,
        input logic [15:0] a);
        logic [7:0] b[4];
        b = '{b0, b1, b2, b3};
        for (int i = 0; i < n; i++) begin
            fm.put(b[i], a + 16'(i));
        end
        `CHK("valid", 1'b1, d.valid)
        `CHK("opcode", b0, d.opcode)
    endtask
    task automatic gap();
        fm.idle();
        `CHK("valid pulse", 1'b0, d.valid)
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_add();
        instr(OP_ADD_RR, 8'h08, 8'h43, 8'h00, 3, 16'h0100);
        `CHK("add src", 12'h008, d.src_reg)
        `CHK("add dst", 12'h043, d.dst_reg)
        instr(OP_ADD_IR, 8'h08, 8'hea, 8'h00, 3, 16'h0106);
        `CHK("ir src", 12'h008, d.src_reg)
        `CHK("esc dst", 12'h03a, d.dst_reg)
        wgp = 8'h5c;
        instr(OP_ADD_RR, 8'he8, 8'hff, 8'h00, 3, 16'h0103);
        `CHK("esc src", 12'h058, d.src_reg)
        `CHK("full dst", 12'h0ff, d.dst_reg)
        gap();
        `CHK("held dst", 12'h0ff, d.dst_reg)
        wgp = 8'h30;
    endtask
    task automatic t_imm();
        instr(OP_ADD_IM, 8'h12, 8'hff, 8'h00, 3, 16'h0200);
        `CHK("imm dst", 12'h012, d.dst_reg)
        `CHK("imm data", 8'hff, d.literal_byte_operand)
    endtask
    task automatic t_jr();
        instr(OP_JR, 8'h80, 8'h00, 8'h00, 2, 16'h1000);
        `CHK("jr back", 16'h0f82, d.branch_target)
        instr(OP_JR, 8'h7f, 8'h00, 8'h00, 2, 16'hfffe);
        `CHK("jr fwd", 16'h007f, d.branch_target)
    endtask
    task automatic t_da();
        instr(OP_JP_DA, 8'hff, 8'hff, 8'h00, 3, 16'h0300);
        `CHK("jp da", 16'hffff, d.absolute_target_operand)
        instr(OP_CALL_DA, 8'h12, 8'h34, 8'h00, 3, 16'h0303);
        `CHK("call da", 16'h1234, d.absolute_target_operand)
    endtask
    task automatic t_trap();
        instr(OP_TRAP, 8'ha5, 8'h00, 8'h00, 2, 16'h0400);
        `CHK("vector", 8'ha5, d.trap_vector)
    endtask
    // every bit number, polarity the inverse of its low bit
    task automatic t_bit();
        for (int i = 0; i < 8; i++) begin
            instr(OP_BIT, {!i[0], 3'(i), 4'h5}, 8'h00, 8'h00, 3, 16'h0500);
            `CHK("bit num", 3'(i), d.bit_num)
            `CHK("polarity", !i[0], d.polarity)
            `CHK("bit reg", 12'h035, d.dst_reg)
        end
    endtask
    task automatic t_pair();
        instr(OP_INCW, 8'h35, 8'h00, 8'h00, 2, 16'h0600);
        `CHK("pair odd", 12'h034, d.dst_reg)
        instr(OP_INCW, 8'hff, 8'h00, 8'h00, 2, 16'h0602);
        `CHK("pair top", 12'h0fe, d.dst_reg)
        instr(OP_INCW_WP, 8'he7, 8'h00, 8'h00, 2, 16'h0604);
        `CHK("wpair", 12'h036, d.dst_reg)
    endtask
    task automatic t_ext();
        instr(OP_LDX, 8'h12, 8'h34, 8'h56, 4, 16'h0700);
        `CHK("ext src", 12'h123, d.src_reg)
        `CHK("ext dst", 12'h456, d.dst_reg)
        instr(OP_LDX, 8'hff, 8'hff, 8'hff, 4, 16'h0704);
        `CHK("ext top", 24'hffffff, {d.src_reg, d.dst_reg})
    endtask
    task automatic t_idx();
        instr(OP_LDX_IDX, 8'h20, 8'h80, 8'h00, 3, 16'h0800);
        `CHK("index min", 8'h80, d.index_disp)
        `CHK("index reg", 12'h020, d.src_reg)
        instr(OP_LDX_IDX, 8'h20, 8'h7f, 8'h00, 3, 16'h0803);
        `CHK("index max", 8'h7f, d.index_disp)
    endtask
    // unknown opcode, then decoding resumes at the next byte
    task automatic t_ill();
        instr(8'hff, 8'h00, 8'h00, 8'h00, 1, 16'h0900);
        `CHK("illegal", 1'b1, d.illegal)
        instr(OP_ADD_RR, 8'h01, 8'h02, 8'h00, 3, 16'h0901);
        `CHK("after ill", 1'b0, d.illegal)
    endtask
    // reset in mid instruction drops the partial bytes
    task automatic t_rst();
        fm.put(OP_ADD_RR, 16'h0a00);
        fm.put(8'h08, 16'h0a01);
        reset = 1'b1;
        fm.idle();
        `CHK("reset out", '0, decode_raw)
        reset = 1'b0;
        instr(OP_ADD_RR, 8'h09, 8'h44, 8'h00, 3, 16'h0a02);
        `CHK("post rst", 12'h044, d.dst_reg)
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic finish_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // about 85 cycles of traffic, so 2500 is ample
    initial begin
        #20000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        t_add();
        t_imm();
        t_jr();
        t_da();
        t_trap();
        t_bit();
        t_pair();
        t_ext();
        t_idx();
        t_ill();
        t_rst();
        gap();
        finish_test();
    end
endmodule
`default_nettype wire

// file: testbench/ofd_fetch_model.sv
/*
 * Fetch unit model: offers one instruction byte per cycle to the decoder.
 * Assumes the caller enters each task at a falling clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module ofd_fetch_model (
    // clock
    input wire logic clk_i,
    // byte stream towards the decoder
    output logic valid_o,
    output ofd_pkg::ofd_fetch_t fetch_o
);
    import ofd_pkg::*;
    logic [7:0] last = 8'h00;
    // ----------------------------------------
    // stream driving
    // ----------------------------------------
    initial begin
        valid_o = 1'b0;
        fetch_o = '0;
    end
    task automatic put(input logic [7:0] b, input logic [15:0] a);
        valid_o = 1'b1;
        fetch_o = '{byte_val: b, addr: a};
        last = b;
        @(negedge clk_i);
    endtask
    // stale byte inverted so a decoder reading it on a gap is caught
    task automatic idle();
        valid_o = 1'b0;
        fetch_o.byte_val = ~last;
        @(negedge clk_i);
    endtask
endmodule
`default_nettype wire
